// [rtl/sps_pkg.sv]
// Constants for the multichannel serial port with slot select and DMA.
// Assumes one register index per word on a plain strobe bus.
package sps_pkg;
	// ----------------------------------------
	// Register indexes
	// ----------------------------------------
	localparam logic [4:0] SPS_CTL      = 5'h00;
	localparam logic [4:0] SPS_MCTL     = 5'h01;
	localparam logic [4:0] SPS_TXBUF    = 5'h02;
	localparam logic [4:0] SPS_RXBUF    = 5'h03;
	localparam logic [4:0] SPS_INDEX    = 5'h04;
	localparam logic [4:0] SPS_STEP     = 5'h05;
	localparam logic [4:0] SPS_COUNT    = 5'h06;
	localparam logic [4:0] SPS_CHAIN    = 5'h07;
	localparam logic [4:0] SPS_TXSEL    = 5'h08;
	localparam logic [4:0] SPS_TXCMP    = 5'h0c;
	localparam logic [4:0] SPS_RXSEL    = 5'h10;
	localparam logic [4:0] SPS_RXCMP    = 5'h14;
	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int SPS_B_EN     = 0;
	localparam int SPS_B_DIR    = 1;
	localparam int SPS_B_FMT    = 2;
	localparam int SPS_B_MERGE  = 3;
	localparam int SPS_B_DMAEN  = 4;
	localparam int SPS_B_CHEN   = 5;
	localparam int SPS_B_I2S    = 8;
	localparam int SPS_B_LEN    = 9;
	localparam int SPS_B_FILL   = 30;
	localparam int SPS_B_HANG   = 31;
	localparam int SPS_B_CUR    = 8;
	localparam int SPS_B_PCI    = 31;
	// ----------------------------------------
	// Reset values and word length limits
	// ----------------------------------------
	localparam logic [13:0] SPS_CTL_RST  = 14'h0000;
	localparam logic [6:0]  SPS_NCH_RST  = 7'h00;
	localparam logic [31:0] SPS_SEL_RST  = 32'h00000000;
	localparam logic [4:0]  SPS_LEN_MIN  = 5'h02;
	localparam logic [4:0]  SPS_LEN_I2S  = 5'h07;
	localparam logic [4:0]  SPS_LEN_WORD_MERGE_ENABLE = 5'h0f;
	// ----------------------------------------
	// DMA states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SPS_IDLE  = 3'b001,
		SPS_DATA  = 3'b010,
		SPS_FETCH = 3'b100
	} sps_dma_t;
endpackage

// [rtl/sps_port.sv]
// Multichannel TDM serial port: slot select, companding, buffers and DMA.
// Assumes serial clock, frame sync and receive data come from another domain.
`timescale 1ns/100ps
// Overview of operation
// - 128 slots, four 32-bit select words, bit n of word k is slot 32k+n
// - Enabled slots transfer words, disabled slots are ignored
// - Transmitter drives data in selected slots, releases pin otherwise
// - Receiver loads selected slot words into buffer, discards others
// - Compand only flagged slots, A-law or mu-law from format bit
// - Receiver expands companded data, transmitter compresses it
// - Core mode: interrupt while receive word held or transmit buffer free
// - Core read of receive buffer while transmitting, or write of transmit buffer while receiving, hangs until port reset
// - Empty read or full write stalls until status changes; status readable
// - Direction bit zero selects receive buffer, one selects transmit
// - Port DMA request beats other DMA requests in same cycle
// - Word lengths 3 to 32, 8 to 32 in I2S, DMA moves 32 bits
// - Packing joins two short words per 32-bit transfer and interrupt
// - DMA off: interrupt per received word and per transmit vacancy
// - Software loads index, step and count before a DMA run
// - DMA moves words until count reaches zero, then interrupts; mid-chain only if pointer PCI bit set
// - DMA interrupts only at block end; one shared interrupt
// - Chaining fetches next parameter block at chain pointer per direction
// - Chaining off when enable bit clear or pointer address zero
// - Chain insertion: finish block, interrupt always, no block fetch
// - Count decrements by one after every transfer
// - Read-only current slot advances, wrapping at programmed slot count
module sps_port
	import sps_pkg::*;
#(
	parameter int AW = 19
) (
	// Clock and reset
	input  wire logic          CLOCK,
	input  wire logic          RST_N,
	input  wire logic          CE,
	// Register port
	input  wire logic [4:0]    REG_ADDR,
	input  wire logic [31:0]   REG_WDATA,
	input  wire logic          REG_WR,
	input  wire logic          REG_RD,
	output logic      [31:0]   REG_RDATA,
	output logic               REG_STALL,
	// Serial link
	input  wire logic          SER_CLK,
	input  wire logic          SER_FS,
	input  wire logic          SER_RXD,
	output logic               SER_TXD,
	output logic               SER_TXD_OE,
	output logic               SER_TDV,
	// Memory master
	output logic               MEM_REQ,
	output logic               MEM_WE,
	output logic      [AW-1:0] MEM_ADDR,
	output logic      [31:0]   MEM_WDATA,
	input  wire logic          MEM_ACK,
	input  wire logic [31:0]   MEM_RDATA,
	// Other DMA channels
	input  wire logic          OTHER_DMA_REQ,
	output logic               OTHER_DMA_GNT,
	// Interrupt
	output logic               PORT_IRQ
);
	initial begin
		if (AW < 4 || AW > 30) $error("sps_port: AW out of range");
	end

	// ----------------------------------------
	// Companding
	// ----------------------------------------
	function automatic logic [7:0] sps_compress(input logic [15:0] s, input logic alaw);
		logic [15:0] mag;
		logic [13:0] m;
		logic [13:0] sh;
		logic [2:0]  seg;
		begin
			mag = s[15] ? (~s + 16'h0001) : s;
			if (alaw)
				m = {1'b0, mag[15:3]};
			else if (mag[15:2] > 14'h1fde)
				m = 14'h1fff;
			else
				m = mag[15:2] + 14'h0021;
			seg = 3'h0;
			for (int i = 1; i < 8; i++) begin
				if (alaw ? m[4 + i] : m[5 + i]) seg = 3'(i);
			end
			if (alaw)
				sh = (seg == 3'h0) ? (m >> 1) : (m >> seg);
			else
				sh = m >> ({1'b0, seg} + 4'h1);
			if (alaw)
				sps_compress = {~s[15], seg, sh[3:0]} ^ 8'h55;
			else
				sps_compress = ~{s[15], seg, sh[3:0]};
		end
	endfunction

	function automatic logic [15:0] sps_expand(input logic [7:0] code, input logic alaw);
		logic [7:0]  c;
		logic [15:0] t;
		begin
			c = alaw ? (code ^ 8'h55) : ~code;
			if (alaw) begin
				t = {8'h00, c[3:0], 4'h8};
				if (c[6:4] != 3'h0) t = t + 16'h0100;
				if (c[6:4] > 3'h1) t = t << (c[6:4] - 3'h1);
				sps_expand = c[7] ? t : (~t + 16'h0001);
			end else begin
				t = ({9'h000, c[3:0], 3'h0} + 16'h0084) << c[6:4];
				t = t - 16'h0084;
				sps_expand = c[7] ? (~t + 16'h0001) : t;
			end
		end
	endfunction

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [13:0]   ctl_reg, ctl_next;
	logic [6:0]    nch_reg, nch_next;
	logic [31:0]   sel_reg [16];
	logic [31:0]   sel_next [16];
	logic [31:0]   txbuf_reg, txbuf_next, rxbuf_reg, rxbuf_next;
	logic          txfull_reg, txfull_next, rxfull_reg, rxfull_next;
	logic          hang_reg, hang_next, irq_reg, irq_next;
	logic [31:0]   rdata_reg, rdata_next;
	logic [AW-1:0] index_reg, index_next, step_reg, step_next;
	logic [31:0]   count_reg, count_next;
	logic [AW:0]   chain_reg, chain_next;
	logic [1:0]    fidx_reg, fidx_next;
	sps_dma_t      st_reg, st_next;

	logic en, dir, alaw, merge, dmaen, chen;
	logic [4:0] len;
	assign en    = ctl_reg[SPS_B_EN];
	assign dir   = ctl_reg[SPS_B_DIR];
	assign alaw  = ctl_reg[SPS_B_FMT];
	assign merge = ctl_reg[SPS_B_MERGE];
	assign dmaen = ctl_reg[SPS_B_DMAEN];
	assign chen  = ctl_reg[SPS_B_CHEN];

	// Clamp length: 3 bits minimum, 8 in I2S mode
	always_comb begin
		len = ctl_reg[SPS_B_LEN +: 5];
		if (len < SPS_LEN_MIN) len = SPS_LEN_MIN;
		if (ctl_reg[SPS_B_I2S] && len < SPS_LEN_I2S) len = SPS_LEN_I2S;
	end

	// ----------------------------------------
	// Link input synchronisers
	// ----------------------------------------
	logic [2:0] sclk_sy;
	logic [1:0] fs_sy, rxd_sy;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_sy <= 3'h0;
			fs_sy   <= 2'h0;
			rxd_sy  <= 2'h0;
		end else if (CE) begin
			sclk_sy <= {sclk_sy[1:0], SER_CLK};
			fs_sy   <= {fs_sy[0], SER_FS};
			rxd_sy  <= {rxd_sy[0], SER_RXD};
		end
	end
	logic rise;
	assign rise = sclk_sy[1] & ~sclk_sy[2];

	// ----------------------------------------
	// Serial engine
	// ----------------------------------------
	logic [4:0]  bit_reg, bit_next, pbit;
	logic [6:0]  slot_reg, slot_next, pslot;
	logic        seen_reg, seen_next, half_reg, half_next;
	logic [31:0] rsh_reg, rsh_next, tw_reg, tw_next, cur_w;
	logic [15:0] rlow_reg, rlow_next;
	logic        txd_reg, txd_next, oe_reg, oe_next;
	logic        sel, cmp, tx_take, rx_push;
	logic [31:0] rx_word, src, mask;

	always_comb begin
		bit_next  = bit_reg;
		slot_next = slot_reg;
		seen_next = seen_reg;
		half_next = half_reg;
		rsh_next  = rsh_reg;
		tw_next   = tw_reg;
		rlow_next = rlow_reg;
		txd_next  = txd_reg;
		oe_next   = oe_reg;
		tx_take   = 1'b0;
		rx_push   = 1'b0;
		rx_word   = rsh_reg;
		src       = 32'h00000000;
		cur_w     = tw_reg;
		mask      = 32'hffffffff >> (5'h1f - len);
		if (fs_sy[1]) begin
			pbit  = 5'h00;
			pslot = 7'h00;
		end else if (bit_reg == len) begin
			pbit  = 5'h00;
			pslot = (slot_reg == nch_reg) ? 7'h00 : slot_reg + 7'h01;
		end else begin
			pbit  = bit_reg + 5'h01;
			pslot = slot_reg;
		end
		sel = sel_reg[{dir ? 2'h0 : 2'h2, pslot[6:5]}][pslot[4:0]];
		cmp = sel_reg[{dir ? 2'h1 : 2'h3, pslot[6:5]}][pslot[4:0]];
		if (!en) begin
			seen_next = 1'b0;
			half_next = 1'b0;
			oe_next   = 1'b0;
		end else if (rise && (seen_reg || fs_sy[1])) begin
			seen_next = 1'b1;
			bit_next  = pbit;
			slot_next = pslot;
			rsh_next  = {rsh_reg[30:0], rxd_sy[1]};
			if (dir) begin
				if (pbit == 5'h00 && sel) begin
					// Underrun sends zero, compressed in companded slots, rather than stale data
					if (txfull_reg) src = (merge && half_reg) ? {16'h0000, txbuf_reg[31:16]}
						: txbuf_reg;
					if (cmp) src = {24'h000000, sps_compress(src[15:0], alaw)};
					cur_w   = src;
					tw_next = src;
					if (txfull_reg) begin
						half_next = merge & ~half_reg;
						tx_take   = ~(merge & ~half_reg);
					end
				end
				txd_next = cur_w[len - pbit];
				oe_next  = sel;
			end else begin
				oe_next = 1'b0;
				if (pbit == len && sel) begin
					rx_word = rsh_next & mask;
					if (cmp) rx_word = {{16{1'b0}}, sps_expand(rx_word[7:0], alaw)};
					if (cmp && !merge) rx_word[31:16] = {16{rx_word[15]}};
					if (merge && !half_reg) begin
						rlow_next = rx_word[15:0];
						half_next = 1'b1;
					end else begin
						if (merge) rx_word = {rx_word[15:0], rlow_reg};
						half_next = 1'b0;
						rx_push   = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			bit_reg  <= 5'h00;
			slot_reg <= 7'h00;
			seen_reg <= 1'b0;
			half_reg <= 1'b0;
			rsh_reg  <= 32'h00000000;
			tw_reg   <= 32'h00000000;
			rlow_reg <= 16'h0000;
			txd_reg  <= 1'b0;
			oe_reg   <= 1'b0;
		end else if (CE) begin
			bit_reg  <= bit_next;
			slot_reg <= slot_next;
			seen_reg <= seen_next;
			half_reg <= half_next;
			rsh_reg  <= rsh_next;
			tw_reg   <= tw_next;
			rlow_reg <= rlow_next;
			txd_reg  <= txd_next;
			oe_reg   <= oe_next;
		end
	end

	// ----------------------------------------
	// Registers, buffers and DMA
	// ----------------------------------------
	logic rd_rx, wr_tx, bad, busy, run, need, ack, last;
	logic [AW-1:0] cp_addr;
	assign cp_addr = chain_reg[AW-1:0];

	always_comb begin
		ctl_next    = ctl_reg;
		nch_next    = nch_reg;
		sel_next    = sel_reg;
		txbuf_next  = txbuf_reg;
		rxbuf_next  = rxbuf_reg;
		txfull_next = txfull_reg;
		rxfull_next = rxfull_reg;
		hang_next   = hang_reg & en;
		rdata_next  = 32'h00000000;
		index_next  = index_reg;
		step_next   = step_reg;
		count_next  = count_reg;
		chain_next  = chain_reg;
		fidx_next   = fidx_reg;
		st_next     = st_reg;
		irq_next    = 1'b0;
		MEM_REQ     = 1'b0;
		MEM_WE      = 1'b0;
		MEM_ADDR    = index_reg;
		rd_rx = REG_RD && REG_ADDR == SPS_RXBUF;
		wr_tx = REG_WR && REG_ADDR == SPS_TXBUF;
		bad   = en && ((rd_rx && dir) || (wr_tx && !dir));
		if (bad) hang_next = 1'b1;
		REG_STALL = hang_reg || bad || (rd_rx && !rxfull_reg) || (wr_tx && txfull_reg);
		// Serial side
		if (tx_take) txfull_next = 1'b0;
		// Bus writes
		if (REG_WR && !REG_STALL) begin
			case (REG_ADDR)
				SPS_CTL:   ctl_next = REG_WDATA[13:0];
				SPS_MCTL:  nch_next = REG_WDATA[6:0];
				SPS_TXBUF: begin
					txbuf_next  = REG_WDATA;
					txfull_next = 1'b1;
				end
				SPS_INDEX: index_next = REG_WDATA[AW-1:0];
				SPS_STEP:  step_next  = REG_WDATA[AW-1:0];
				SPS_COUNT: count_next = REG_WDATA;
				SPS_CHAIN: begin
					chain_next = {REG_WDATA[SPS_B_PCI], REG_WDATA[AW-1:0]};
					if (dmaen && chen && REG_WDATA[AW-1:0] != '0 && st_reg == SPS_IDLE) begin
						st_next   = SPS_FETCH;
						fidx_next = 2'h0;
					end
				end
				default: begin
					if (REG_ADDR >= SPS_TXSEL && REG_ADDR < SPS_RXCMP + 5'h04)
						sel_next[4'(REG_ADDR - SPS_TXSEL)] = REG_WDATA;
				end
			endcase
		end
		// Bus reads
		if (REG_RD && !REG_STALL) begin
			case (REG_ADDR)
				SPS_CTL: begin
					rdata_next[13:0]        = ctl_reg;
					rdata_next[SPS_B_FILL] = dir ? txfull_reg : rxfull_reg;
					rdata_next[SPS_B_HANG] = hang_reg;
				end
				SPS_MCTL:  rdata_next = {17'h00000, slot_reg, 1'b0, nch_reg};
				SPS_TXBUF: rdata_next = txbuf_reg;
				SPS_RXBUF: begin
					rdata_next  = rxbuf_reg;
					rxfull_next = 1'b0;
				end
				SPS_INDEX: rdata_next = 32'(index_reg);
				SPS_STEP:  rdata_next = 32'(step_reg);
				SPS_COUNT: rdata_next = count_reg;
				SPS_CHAIN: begin
					rdata_next             = 32'(cp_addr);
					rdata_next[SPS_B_PCI] = chain_reg[AW];
				end
				default: begin
					if (REG_ADDR >= SPS_TXSEL && REG_ADDR < SPS_RXCMP + 5'h04)
						rdata_next = sel_reg[4'(REG_ADDR - SPS_TXSEL)];
				end
			endcase
		end
		// DMA engine; insertion mode keeps the block running
		busy = dmaen | chen;
		run  = en && busy && count_reg != 32'h00000000;
		need = dir ? !txfull_reg : rxfull_reg;
		ack  = 1'b0;
		last = count_reg == 32'h00000001;
		case (st_reg)
			SPS_IDLE: begin
				// A chain start written this cycle keeps priority over a data move
				if (run && need && st_next == SPS_IDLE) st_next = SPS_DATA;
			end
			SPS_DATA: begin
				MEM_REQ = 1'b1;
				MEM_WE  = ~dir;
				ack     = MEM_ACK;
				if (!busy || !en) st_next = SPS_IDLE;
				else if (ack) begin
					if (dir) begin
						txbuf_next  = MEM_RDATA;
						txfull_next = 1'b1;
					end else rxfull_next = 1'b0;
					index_next = index_reg + step_reg;
					count_next = count_reg - 32'h00000001;
					st_next    = SPS_IDLE;
					if (last) begin
						if (dmaen && chen && cp_addr != '0) begin
							st_next   = SPS_FETCH;
							fidx_next = 2'h0;
							irq_next  = chain_reg[AW];
						end else irq_next = 1'b1;
					end
				end
			end
			SPS_FETCH: begin
				MEM_REQ  = 1'b1;
				MEM_ADDR = cp_addr + AW'(fidx_reg);
				if (!chen || !en) st_next = SPS_IDLE;
				else if (MEM_ACK) begin
					case (fidx_reg)
						2'h0:    index_next = MEM_RDATA[AW-1:0];
						2'h1:    step_next  = MEM_RDATA[AW-1:0];
						2'h2:    count_next = MEM_RDATA;
						default: chain_next = {MEM_RDATA[SPS_B_PCI], MEM_RDATA[AW-1:0]};
					endcase
					fidx_next = fidx_reg + 2'h1;
					if (fidx_reg == 2'h3) st_next = SPS_IDLE;
				end
			end
			default: st_next = SPS_IDLE;
		endcase
		// Serial push last so a new word wins over a drain
		if (rx_push) begin
			rxbuf_next  = rx_word;
			rxfull_next = 1'b1;
		end
		if (en && !busy) irq_next = dir ? !txfull_reg : rxfull_reg;
		if (!en) hang_next = 1'b0;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ctl_reg    <= SPS_CTL_RST;
			nch_reg    <= SPS_NCH_RST;
			for (int i = 0; i < 16; i++) sel_reg[i] <= SPS_SEL_RST;
			txbuf_reg  <= 32'h00000000;
			rxbuf_reg  <= 32'h00000000;
			txfull_reg <= 1'b0;
			rxfull_reg <= 1'b0;
			hang_reg   <= 1'b0;
			irq_reg    <= 1'b0;
			rdata_reg  <= 32'h00000000;
			index_reg  <= '0;
			step_reg   <= '0;
			count_reg  <= 32'h00000000;
			chain_reg  <= '0;
			fidx_reg   <= 2'h0;
			st_reg     <= SPS_IDLE;
		end else if (CE) begin
			ctl_reg    <= ctl_next;
			nch_reg    <= nch_next;
			sel_reg    <= sel_next;
			txbuf_reg  <= txbuf_next;
			rxbuf_reg  <= rxbuf_next;
			txfull_reg <= txfull_next;
			rxfull_reg <= rxfull_next;
			hang_reg   <= hang_next;
			irq_reg    <= irq_next;
			rdata_reg  <= rdata_next;
			index_reg  <= index_next;
			step_reg   <= step_next;
			count_reg  <= count_next;
			chain_reg  <= chain_next;
			fidx_reg   <= fidx_next;
			st_reg     <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign REG_RDATA     = rdata_reg;
	assign MEM_WDATA     = rxbuf_reg;
	assign OTHER_DMA_GNT = OTHER_DMA_REQ & ~MEM_REQ;
	assign SER_TXD       = txd_reg;
	assign SER_TXD_OE    = oe_reg;
	assign SER_TDV       = oe_reg;
	assign PORT_IRQ      = irq_reg;
endmodule // sps_port

// [sim/sps_link_model.sv]
// Behavioural TDM partner: makes serial clock and frame sync, sends and catches bits.
// Assumes the port samples and drives on the rising serial clock edge.
`timescale 1ns/100ps
module sps_link_model (
	// Link out
	output logic      ser_clk,
	output logic      ser_fs,
	output logic      ser_rxd,
	// Link in
	input  wire logic ser_txd,
	input  wire logic ser_txd_oe
);
	logic [31:0] tx_cap;
	int          oe_bits;
	initial begin
		ser_clk = 1'b0;
		ser_fs = 1'b0;
		ser_rxd = 1'b0;
		tx_cap = 32'h0;
		oe_bits = 0;
	end
	// Clock stands low between frames; offset keeps it off the system clock edge
	task automatic frame(input int nbits, input logic [31:0] rx);
		#3;
		for (int i = 0; i < nbits; i++) begin
			ser_fs = (i == 0);
			ser_rxd = rx[(nbits - 1 - i) % 32];
			#40 ser_clk = 1'b1;
			#40 ser_clk = 1'b0;
			if (ser_txd_oe) begin
				tx_cap = {tx_cap[30:0], ser_txd};
				oe_bits++;
			end
		end
		ser_fs = 1'b0;
		// No pull on the data line: show the inverse, not a held value
		ser_rxd = ~ser_rxd;
	endtask
endmodule // sps_link_model

// [sim/sps_port_sva.sv]
// Assertion checker for the slot select serial port, watching top ports only.
// Assumes it is bound into every sps_port instance; one clock domain.
`timescale 1ns/100ps
module sps_port_sva #(
	parameter int AW = 19
) (
	// Clock and reset
	input wire logic          CLOCK,
	input wire logic          RST_N,
	// Register port
	input wire logic          REG_WR,
	input wire logic          REG_RD,
	input wire logic [31:0]   REG_RDATA,
	input wire logic          REG_STALL,
	// Serial link
	input wire logic          SER_CLK,
	input wire logic          SER_TXD,
	input wire logic          SER_TXD_OE,
	input wire logic          SER_TDV,
	// DMA
	input wire logic          MEM_REQ,
	input wire logic          MEM_ACK,
	input wire logic [AW-1:0] MEM_ADDR,
	input wire logic          OTHER_DMA_REQ,
	input wire logic          OTHER_DMA_GNT
);
	logic rd_refused;
	assign rd_refused = REG_RD && REG_STALL;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_port_wins: assert property (OTHER_DMA_GNT == (OTHER_DMA_REQ && !MEM_REQ))
		else $error("other channel granted beside port request");
	a_req_holds: assert property (MEM_REQ && !MEM_ACK && !REG_WR |=> MEM_REQ && $stable(MEM_ADDR))
		else $error("memory request dropped before acknowledge");
	a_tdv_mirror: assert property (SER_TDV == SER_TXD_OE)
		else $error("data valid differs from output enable");
	a_oe_on_edge: assert property ($changed(SER_TXD_OE) |-> $past(SER_CLK, 2))
		else $error("output enable moved without serial clock rise");
	a_txd_on_edge: assert property ($changed(SER_TXD) |-> $past(SER_CLK, 2))
		else $error("transmit data moved without serial clock rise");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside read answer cycle");
	a_stall_nodata: assert property ($past(rd_refused) |-> REG_RDATA == 32'h0)
		else $error("refused read returned data");
	a_hang_sticks: assert property (REG_STALL && !REG_RD && !REG_WR |=> REG_STALL)
		else $error("hang released without reset");
endmodule // sps_port_sva

bind sps_port sps_port_sva #(.AW(AW)) i_sva (.CLOCK(CLOCK), .RST_N(RST_N), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_STALL(REG_STALL), .SER_CLK(SER_CLK),
	.SER_TXD(SER_TXD), .SER_TXD_OE(SER_TXD_OE), .SER_TDV(SER_TDV), .MEM_REQ(MEM_REQ),
	.MEM_ACK(MEM_ACK), .MEM_ADDR(MEM_ADDR), .OTHER_DMA_REQ(OTHER_DMA_REQ),
	.OTHER_DMA_GNT(OTHER_DMA_GNT));

// [sim/sps_port_tb.sv]
// Self-checking bench for sps_port: registers, serial slots, stalls and DMA.
// Assumes the link partner model and the bound assertion checker.
`timescale 1ns/100ps
`define SPS_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end
module sps_port_tb import sps_pkg::*; ;
	logic        CLOCK, RST_N, REG_WR, REG_RD, REG_STALL, SER_CLK, SER_FS, SER_RXD;
	logic        SER_TXD, SER_TXD_OE, SER_TDV, MEM_REQ, MEM_WE, MEM_ACK, stall_seen;
	logic        OTHER_DMA_REQ, OTHER_DMA_GNT, PORT_IRQ;
	logic [4:0]  REG_ADDR;
	logic [18:0] MEM_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA, MEM_WDATA, MEM_RDATA, d;
	logic [33:0] wr_seen;
	logic [31:0] mem [0:3];
	logic [18:0] aq [$];
	logic [18:0] ea [5] = '{19'h200, 19'h201, 19'h202, 19'h203, 19'h300};
	int          error_cnt, tests_run, irq_cnt;

	sps_port #(.AW(19)) i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.REG_STALL(REG_STALL), .SER_CLK(SER_CLK), .SER_FS(SER_FS), .SER_RXD(SER_RXD),
		.SER_TXD(SER_TXD), .SER_TXD_OE(SER_TXD_OE), .SER_TDV(SER_TDV), .MEM_REQ(MEM_REQ),
		.MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
		.MEM_RDATA(MEM_RDATA), .OTHER_DMA_REQ(OTHER_DMA_REQ), .OTHER_DMA_GNT(OTHER_DMA_GNT),
		.PORT_IRQ(PORT_IRQ));
	sps_link_model i_link (.ser_clk(SER_CLK), .ser_fs(SER_FS), .ser_rxd(SER_RXD),
		.ser_txd(SER_TXD), .ser_txd_oe(SER_TXD_OE));

	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	// Memory answers in the cycle after a request; completed addresses are logged
	always @(posedge CLOCK) begin
		MEM_ACK <= MEM_REQ && !MEM_ACK;
		MEM_RDATA <= mem[MEM_ADDR[1:0]];
		if (!RST_N) begin
			aq.delete();
			irq_cnt = 0;
		end else begin
			if (MEM_REQ && MEM_ACK) begin
				aq.push_back(MEM_ADDR);
				wr_seen = {MEM_WE, OTHER_DMA_GNT, MEM_WDATA};
			end
			if (PORT_IRQ)
				irq_cnt++;
		end
	end
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] wd);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= wd;
		REG_WR <= w;
		REG_RD <= !w;
		@(posedge CLOCK);
		stall_seen = REG_STALL;
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		acc(1'b1, a, v);
	endtask
	task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
		acc(1'b0, a, 32'h0);
		`SPS_CHK(nm, e, d)
	endtask
	task automatic wait_mem(input int n);
		for (int i = 0; i < 200 && aq.size() < n; i++)
			@(posedge CLOCK);
	endtask
	task automatic do_reset();
		RST_N <= 1'b0;
		repeat (5) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(posedge CLOCK);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		error_cnt++;
		complete_run();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{RST_N, REG_WR, REG_RD, OTHER_DMA_REQ} = 4'h0;
		REG_ADDR = 5'h00;
		REG_WDATA = 32'h0;
		error_cnt = 0;
		tests_run = 0;
		mem = '{32'h300, 32'h4, 32'h1, 32'h0};
		do_reset();
		rc(SPS_CTL, 32'h0, "ctl reset");
		for (int k = 8; k < 24; k++) rc(5'(k), SPS_SEL_RST, "select reset");
		wr(SPS_RXCMP + 5'h3, 32'h5a5a0001);
		rc(SPS_RXCMP + 5'h3, 32'h5a5a0001, "compand select");
		rc(5'h1f, 32'h0, "unmapped");
		// Transmit 3-bit word in slot 33 of 35
		wr(SPS_MCTL, 32'h22);
		wr(SPS_TXSEL + 5'h1, 32'h2);
		wr(SPS_CTL, 32'h403);
		rc(SPS_CTL, 32'h403, "ctl tx");
		`SPS_CHK("irq tx vacant", 1'b1, PORT_IRQ)
		wr(SPS_TXBUF, 32'h5);
		wr(SPS_TXBUF, 32'h2);
		`SPS_CHK("stall full", 1'b1, stall_seen)
		rc(SPS_CTL, 32'h40000403, "fill tx");
		`SPS_CHK("irq tx full", 1'b0, PORT_IRQ)
		i_link.frame(105, 32'h0);
		`SPS_CHK("tx driven bits", 32'h3, 32'(i_link.oe_bits))
		`SPS_CHK("tx word", 3'h5, i_link.tx_cap[2:0])
		`SPS_CHK("irq tx drained", 1'b1, PORT_IRQ)
		rc(SPS_MCTL, 32'h2222, "current slot");
		// Receive slot 0 of 2, slot 1 must be dropped
		do_reset();
		wr(SPS_MCTL, 32'h1);
		wr(SPS_RXSEL, 32'h1);
		wr(SPS_CTL, 32'he01);
		i_link.frame(16, 32'h3c45);
		rc(SPS_CTL, 32'h40000e01, "fill rx");
		`SPS_CHK("irq rx word", 1'b1, PORT_IRQ)
		rc(SPS_RXBUF, 32'h3c, "rx slot0");
		acc(1'b0, SPS_RXBUF, 32'h0);
		`SPS_CHK("stall empty", 1'b1, stall_seen)
		// Inactive buffer access hangs until reset
		wr(SPS_TXBUF, 32'h1);
		`SPS_CHK("hang", 1'b1, stall_seen)
		repeat (20) @(posedge CLOCK);
		acc(1'b0, SPS_CTL, 32'h0);
		`SPS_CHK("hang holds", 1'b1, stall_seen)
		do_reset();
		rc(SPS_CTL, 32'h0, "ctl after reset");
		// Standard DMA, other channel asking at the same time
		OTHER_DMA_REQ <= 1'b1;
		wr(SPS_INDEX, 32'h100);
		wr(SPS_STEP, 32'h2);
		wr(SPS_COUNT, 32'h1);
		wr(SPS_CTL, 32'he13);
		wait_mem(1);
		rc(SPS_COUNT, 32'h0, "count");
		rc(SPS_INDEX, 32'h102, "index");
		`SPS_CHK("dma addr", 19'h100, aq[0])
		`SPS_CHK("dma stops", 32'h1, 32'(aq.size()))
		`SPS_CHK("irq pulses", 32'h1, 32'(irq_cnt))
		// Chain start, then splice by insertion while the chain is live
		do_reset();
		mem = '{32'h300, 32'h4, 32'h2, 32'h200};
		wr(SPS_TXSEL, 32'h1);
		wr(SPS_CHAIN, 32'h0);
		wr(SPS_CTL, 32'he33);
		wr(SPS_CHAIN, 32'h200);
		wait_mem(5);
		foreach (ea[i]) `SPS_CHK("chain addr", ea[i], aq[i])
		wr(SPS_CTL, 32'he23);
		i_link.frame(8, 32'h0);
		wait_mem(6);
		rc(SPS_INDEX, 32'h308, "ins index");
		rc(SPS_COUNT, 32'h0, "ins count");
		`SPS_CHK("ins no fetch", 32'h6, 32'(aq.size()))
		`SPS_CHK("ins irq", 32'h1, 32'(irq_cnt))
		// Receive DMA of an A-law slot; I2S lifts a zero length field to 8 bits
		do_reset();
		wr(SPS_INDEX, 32'h40);
		wr(SPS_COUNT, 32'h1);
		wr(SPS_RXSEL, 32'h1);
		wr(SPS_RXCMP, 32'h1);
		wr(SPS_CTL, 32'h115);
		i_link.frame(8, 32'hd5);
		wait_mem(1);
		rc(SPS_CTL, 32'h115, "rx drained");
		`SPS_CHK("rx dma addr", 19'h40, aq[0])
		`SPS_CHK("rx dma word", 32'h8, wr_seen[31:0])
		`SPS_CHK("rx dma we gnt", 2'h2, wr_seen[33:32])
		`SPS_CHK("rx dma irq", 32'h1, 32'(irq_cnt))
		complete_run();
	end
endmodule // sps_port_tb
